// [rtl/pwm_art_pkg.sv]
// Constants, field layouts and carrier types of the PWM auto-reload timer
`default_nettype none

package pwm_art_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int unsigned PWM_CHANNELS = 4;
   localparam int unsigned CAP_CHANNELS = 2;
   localparam int unsigned PRESCALE_W = 7;

   // ---------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [5:0] IDX_DUTY1 = 6'h14;
   localparam logic [5:0] IDX_DUTY0 = 6'h15;
   localparam logic [5:0] IDX_PWM_CTRL = 6'h16;
   localparam logic [5:0] IDX_TIMER_CSR = 6'h17;
   localparam logic [5:0] IDX_COUNTER = 6'h18;
   localparam logic [5:0] IDX_RELOAD = 6'h19;
   localparam logic [5:0] IDX_CAPTURE_CSR = 6'h1a;
   localparam logic [5:0] IDX_CAPTURE1 = 6'h1b;
   localparam logic [5:0] IDX_CAPTURE2 = 6'h1c;
   localparam logic [5:0] IDX_DUTY2 = 6'h1d;
   localparam logic [5:0] IDX_DUTY3 = 6'h1e;

   // ---------------------------------------------------------------
   // Reset values and counter limits
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 7'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned PWMC_OE_LSB = 4;
   localparam int unsigned PWMC_OP_LSB = 0;
   localparam int unsigned CAPC_EDGE_LSB = 4;
   localparam int unsigned CAPC_IE_LSB = 2;
   localparam int unsigned CAPC_FLAG_LSB = 0;

   // Timer control/status byte, MSB first
   typedef struct packed {
      logic       ext_clock_select;
      logic [2:0] clock_divider_select;
      logic       counter_enable_bit;
      logic       force_reload;
      logic       overflow_irq_enable;
      logic       overflow_flag;
   } timer_csr_s;

endpackage : pwm_art_pkg

`default_nettype wire

// [rtl/pwm_autoreload_timer.sv]
// PWM auto-reload timer with capture channels and Avalon-MM register slave
`default_nettype none

module pwm_autoreload_timer
   import pwm_art_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic halt_i,
   input wire logic external_event_clock_i,
   input wire logic [CAP_CHANNELS-1:0] capture_input_pin_i,
   output logic [PWM_CHANNELS-1:0] pwm_pin_o,
   output logic [PWM_CHANNELS-1:0] pwm_pin_oe_n_o,
   output logic overflow_irq_o,
   output logic [CAP_CHANNELS-1:0] capture_irq_o
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Low sel bits of the prescaler all ones: the tap fires next tick
   function automatic logic tap_hit(input logic [PRESCALE_W-1:0] pre,
                                    input logic [2:0] sel);
      logic [7:0] mask;
      mask = (8'h01 << sel) - 8'h01;
      return (pre & mask[PRESCALE_W-1:0]) == mask[PRESCALE_W-1:0];
   endfunction

   // Channel edge detect, polarity chosen per channel
   function automatic logic edge_seen(input logic now, input logic prev,
                                      input logic rising);
      return rising ? (now & ~prev) : (~now & prev);
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   timer_csr_s csr_ff;
   logic [7:0] reload_ff;
   logic [7:0] counter_ff;
   logic [PRESCALE_W-1:0] prescaler_ff;
   logic [7:0] duty_ff [PWM_CHANNELS];
   logic [7:0] shadow_ff [PWM_CHANNELS];
   logic [PWM_CHANNELS-1:0] wave_ff;
   logic [PWM_CHANNELS-1:0] out_en_ff;
   logic [PWM_CHANNELS-1:0] polarity_ff;
   logic [CAP_CHANNELS-1:0] cap_edge_sel_ff;
   logic [CAP_CHANNELS-1:0] cap_irq_en_ff;
   logic [CAP_CHANNELS-1:0] cap_flag_ff;
   logic [7:0] cap_value_ff [CAP_CHANNELS];
   logic [CAP_CHANNELS-1:0] cap_pend_ff;
   logic [CAP_CHANNELS-1:0] cap_sync1_ff;
   logic [CAP_CHANNELS-1:0] cap_sync2_ff;
   logic [CAP_CHANNELS-1:0] cap_prev_ff;
   logic ext_sync1_ff;
   logic ext_sync2_ff;
   logic ext_prev_ff;
   logic ack_ff;
   logic [31:0] readdata_ff;
   logic [7:0] nxt_readbyte;

   logic [5:0] idx;
   logic req;
   logic rd_acc;
   logic wr_acc;
   logic ctrl_wr;
   logic [7:0] wbyte;
   logic ext_rise;
   logic run;
   logic pre_tick;
   logic cnt_tick;
   logic load_car;
   logic force_ld;
   logic load_any;
   logic ovf_evt;
   logic csr_rd;
   logic capcsr_rd;
   logic [CAP_CHANNELS-1:0] cap_edge;
   logic [CAP_CHANNELS-1:0] cap_evt;
   timer_csr_s csr_seen;
   logic ovf_clr;
   logic [CAP_CHANNELS-1:0] cap_clr;

   // ---------------------------------------------------------------
   // Avalon-MM slave: one wait state on every access
   // ---------------------------------------------------------------

   // Request is accepted on the edge where ack_ff is high
   assign idx = avs_address_i[7:2];
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_ff;
   assign rd_acc = avs_read_i & ack_ff;
   assign wr_acc = avs_write_i & ack_ff & avs_byteenable_i[0];
   assign wbyte = avs_writedata_i[7:0];
   // Control registers frozen in halt; the CPU is stopped anyway
   assign ctrl_wr = wr_acc & ~halt_i;
   // Reads with side effects on the status flags
   assign csr_rd = rd_acc & (idx == IDX_TIMER_CSR);
   assign capcsr_rd = rd_acc & (idx == IDX_CAPTURE_CSR);

   // Wait-state toggle; drops after each accepted cycle
   // A request held high gets its wait state again
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // Read mux; unmapped indices read zero
   always_comb begin
      nxt_readbyte = 8'h00;
      unique case (idx)
         IDX_DUTY0: nxt_readbyte = duty_ff[0];
         IDX_DUTY1: nxt_readbyte = duty_ff[1];
         IDX_DUTY2: nxt_readbyte = duty_ff[2];
         IDX_DUTY3: nxt_readbyte = duty_ff[3];
         IDX_PWM_CTRL: nxt_readbyte = {out_en_ff, polarity_ff};
         IDX_TIMER_CSR: nxt_readbyte = {csr_ff[7:3], 1'b0, csr_ff[1:0]};
         IDX_COUNTER: nxt_readbyte = counter_ff;
         IDX_RELOAD: nxt_readbyte = reload_ff;
         IDX_CAPTURE_CSR: nxt_readbyte = {2'b00, cap_edge_sel_ff, cap_irq_en_ff, cap_flag_ff};
         IDX_CAPTURE1: nxt_readbyte = cap_value_ff[0];
         IDX_CAPTURE2: nxt_readbyte = cap_value_ff[1];
         default: nxt_readbyte = 8'h00;
      endcase
   end

   // Data sampled in the wait cycle so it stands on the accepting edge
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         readdata_ff <= 32'h0000_0000;
      end else if (avs_read_i & ~ack_ff) begin
         readdata_ff <= {24'h00_0000, nxt_readbyte};
      end
   end
   assign avs_readdata_o = readdata_ff;

   // A read clears only the flags it reported; one set between the
   // snapshot and the accepting edge survives for the next read
   assign csr_seen = timer_csr_s'(readdata_ff[7:0]);
   assign ovf_clr = csr_rd & csr_seen.overflow_flag;
   assign cap_clr = {CAP_CHANNELS{capcsr_rd}} & readdata_ff[CAPC_FLAG_LSB +: CAP_CHANNELS];

   // ---------------------------------------------------------------
   // Clock source, prescaler and counter
   // ---------------------------------------------------------------

   // External event synchroniser; only the second stage is looked at
   // Events faster than half the clock rate are lost
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_sync1_ff <= 1'b0;
         ext_sync2_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
      end else begin
         ext_sync1_ff <= external_event_clock_i;
         ext_sync2_ff <= ext_sync1_ff;
         ext_prev_ff <= ext_sync2_ff;
      end
   end
   assign ext_rise = ext_sync2_ff & ~ext_prev_ff;

   // In halt the CPU clock is stopped, so only event counting survives
   assign run = csr_ff.counter_enable_bit & (~halt_i | csr_ff.ext_clock_select);
   assign pre_tick = run & (csr_ff.ext_clock_select ? ext_rise : 1'b1);
   assign cnt_tick = pre_tick & tap_hit(prescaler_ff, csr_ff.clock_divider_select);

   // Software loads of the counter; either also clears the prescaler
   assign load_car = ctrl_wr & (idx == IDX_COUNTER);
   assign force_ld = ctrl_wr & (idx == IDX_TIMER_CSR) & wbyte[2] & wbyte[3];
   assign load_any = load_car | force_ld;
   // A software load in the same cycle swallows the overflow
   assign ovf_evt = cnt_tick & (counter_ff == COUNT_MAX) & ~load_any;

   // Prescaler; overflow leaves it alone, software loads clear it
   // Seven bits are enough for the eight divider taps
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prescaler_ff <= PRESCALE_RST;
      end else if (load_any) begin
         prescaler_ff <= PRESCALE_RST;
      end else if (pre_tick) begin
         prescaler_ff <= prescaler_ff + 7'h01;
      end
   end

   // Counter; a software load beats a tick in the same cycle
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         counter_ff <= REG_RST;
      end else if (load_car) begin
         counter_ff <= wbyte;
      end else if (force_ld | ovf_evt) begin
         counter_ff <= reload_ff;
      end else if (cnt_tick) begin
         counter_ff <= counter_ff + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------

   // Control fields and overflow flag; one writer, force reload never stored
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         csr_ff <= timer_csr_s'(REG_RST);
      end else begin
         if (ctrl_wr && idx == IDX_TIMER_CSR) begin
            csr_ff.ext_clock_select <= wbyte[7];
            csr_ff.clock_divider_select <= wbyte[6:4];
            csr_ff.counter_enable_bit <= wbyte[3];
            csr_ff.overflow_irq_enable <= wbyte[1];
         end
         // A new overflow wins over the clearing read
         if (ovf_evt) begin
            csr_ff.overflow_flag <= 1'b1;
         end else if (ovf_clr) begin
            csr_ff.overflow_flag <= 1'b0;
         end
      end
   end
   assign overflow_irq_o = csr_ff.overflow_flag & csr_ff.overflow_irq_enable;

   // Reload value and PWM control
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reload_ff <= REG_RST;
         out_en_ff <= '0;
         polarity_ff <= '0;
      end else if (ctrl_wr) begin
         if (idx == IDX_RELOAD) begin
            reload_ff <= wbyte;
         end
         if (idx == IDX_PWM_CTRL) begin
            out_en_ff <= wbyte[PWMC_OE_LSB +: PWM_CHANNELS];
            polarity_ff <= wbyte[PWMC_OP_LSB +: PWM_CHANNELS];
         end
      end
   end

   // Capture control; flags only clear on read
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cap_edge_sel_ff <= '0;
         cap_irq_en_ff <= '0;
      end else if (ctrl_wr && idx == IDX_CAPTURE_CSR) begin
         cap_edge_sel_ff <= wbyte[CAPC_EDGE_LSB +: CAP_CHANNELS];
         cap_irq_en_ff <= wbyte[CAPC_IE_LSB +: CAP_CHANNELS];
      end
   end

   // ---------------------------------------------------------------
   // PWM channels
   // ---------------------------------------------------------------

   // Duty registers, shadows and waveforms, one slice per channel
   for (genvar ch = 0; ch < PWM_CHANNELS; ch++) begin : g_pwm
      // Register index of this channel's duty byte
      localparam logic [5:0] DUTY_IDX = (ch == 0) ? IDX_DUTY0 :
                                        (ch == 1) ? IDX_DUTY1 :
                                        (ch == 2) ? IDX_DUTY2 : IDX_DUTY3;

      // Duty byte as software sees it; unused until overflow
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            duty_ff[ch] <= REG_RST;
         end else if (ctrl_wr && idx == DUTY_IDX) begin
            duty_ff[ch] <= wbyte;
         end
      end

      // Double buffer: duty edits land only at the period boundary
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            shadow_ff[ch] <= REG_RST;
         end else if (ovf_evt) begin
            shadow_ff[ch] <= duty_ff[ch];
         end
      end

      // Raw level high from overflow until the count passes the shadow
      // Frozen in halt so each pin keeps its level
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            wave_ff[ch] <= 1'b0;
         end else if (halt_i) begin
            wave_ff[ch] <= wave_ff[ch];
         end else if (ovf_evt) begin
            wave_ff[ch] <= 1'b1;
         end else if (cnt_tick && counter_ff == shadow_ff[ch]) begin
            wave_ff[ch] <= 1'b0;
         end
      end
   end

   // Polarity acts at once; oe low means the timer owns the pin
   assign pwm_pin_o = wave_ff ^ polarity_ff;
   assign pwm_pin_oe_n_o = ~out_en_ff;

   // ---------------------------------------------------------------
   // Capture channels
   // ---------------------------------------------------------------

   // Capture pin synchronisers and edge history
   // Pins are asynchronous to the timer; two stages settle them
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cap_sync1_ff <= '0;
         cap_sync2_ff <= '0;
         cap_prev_ff <= '0;
      end else begin
         cap_sync1_ff <= capture_input_pin_i;
         cap_sync2_ff <= cap_sync1_ff;
         cap_prev_ff <= cap_sync2_ff;
      end
   end

   for (genvar ch = 0; ch < CAP_CHANNELS; ch++) begin : g_cap
      // Edge of the chosen sense on the settled pin
      assign cap_edge[ch] = edge_seen(cap_sync2_ff[ch], cap_prev_ff[ch],
                                      cap_edge_sel_ff[ch]);
      // Stopped counter has no clock edge, so act without waiting
      assign cap_evt[ch] = cap_pend_ff[ch] & (cnt_tick | ~run);

      // Edge held until the next counter clock edge
      // A fresh edge in the same cycle keeps it pending
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            cap_pend_ff[ch] <= 1'b0;
         end else if (cap_edge[ch]) begin
            cap_pend_ff[ch] <= 1'b1;
         end else if (cap_evt[ch]) begin
            cap_pend_ff[ch] <= 1'b0;
         end
      end

      // Flag: new capture wins over the clearing read
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            cap_flag_ff[ch] <= 1'b0;
         end else if (cap_evt[ch]) begin
            cap_flag_ff[ch] <= 1'b1;
         end else if (cap_clr[ch]) begin
            cap_flag_ff[ch] <= 1'b0;
         end
      end

      // Latch only while the flag is free and not halted
      // Halt keeps the old value, yet the flag still wakes the CPU
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            cap_value_ff[ch] <= REG_RST;
         end else if (cap_evt[ch] && (!cap_flag_ff[ch] || cap_clr[ch]) && !halt_i) begin
            cap_value_ff[ch] <= counter_ff;
         end
      end
   end

   assign capture_irq_o = cap_flag_ff & cap_irq_en_ff;

endmodule : pwm_autoreload_timer

`default_nettype wire

// [tb/pwm_art_assertions.sv]
// Port-level checker for the PWM auto-reload timer, bound to its top module
`default_nettype none

module pwm_art_checker
   import pwm_art_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic halt_i,
   input wire logic [PWM_CHANNELS-1:0] pwm_pin_o,
   input wire logic [PWM_CHANNELS-1:0] pwm_pin_oe_n_o,
   input wire logic overflow_irq_o,
   input wire logic [CAP_CHANNELS-1:0] capture_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Bus transfer taken at this edge
   wire logic acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;

   sequence s_req_rise;
      $rose(avs_read_i | avs_write_i);
   endsequence
   sequence s_one_wait;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   // Flags drop only through an access to their own register
   property p_sticky(irq, idx);
      irq && !(acc && avs_address_i[7:2] == idx) |=> irq;
   endproperty

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_bus_one_wait: assert property (s_req_rise |-> s_one_wait)
      else $error("request not answered after one wait state");
   a_reset_idle: assert property (disable iff (1'b0) !reset_n_i |->
      pwm_pin_oe_n_o == '1 && pwm_pin_o == '0 && !overflow_irq_o && capture_irq_o == '0)
      else $error("outputs not idle in reset");
   a_oe_by_write: assert property (!$stable(pwm_pin_oe_n_o) |->
      $past(acc && avs_write_i && avs_address_i[7:2] == IDX_PWM_CTRL))
      else $error("pin enable moved without a control write");
   a_halt_pwm_hold: assert property ($past(halt_i) |-> $stable(pwm_pin_o))
      else $error("pwm pins moved during halt");
   a_force_reads_0: assert property (avs_read_i && !avs_waitrequest_o |->
      avs_readdata_o[31:8] == '0 &&
      (avs_address_i[7:2] != IDX_TIMER_CSR || !avs_readdata_o[2]))
      else $error("force reload or upper lanes read nonzero");
   a_ovf_sticky: assert property (p_sticky(overflow_irq_o, IDX_TIMER_CSR))
      else $error("overflow request dropped on its own");
   a_cap0_sticky: assert property (p_sticky(capture_irq_o[0], IDX_CAPTURE_CSR))
      else $error("capture 0 request dropped on its own");
   a_cap1_sticky: assert property (p_sticky(capture_irq_o[1], IDX_CAPTURE_CSR))
      else $error("capture 1 request dropped on its own");
endmodule // pwm_art_checker

bind pwm_autoreload_timer pwm_art_checker i_checker (.clk_i, .reset_n_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .halt_i, .pwm_pin_o,
   .pwm_pin_oe_n_o, .overflow_irq_o, .capture_irq_o);

`default_nettype wire

// [tb/pins_model.sv]
// Far-side pin model: event source, capture sources and pulled-up PWM pads
`default_nettype none

module pins_model
   import pwm_art_pkg::*;
(
   input wire logic clk_i,
   input wire logic [PWM_CHANNELS-1:0] pwm_pin_o,
   input wire logic [PWM_CHANNELS-1:0] pwm_pin_oe_n_o,
   output logic event_o,
   output logic [CAP_CHANNELS-1:0] cap_o,
   output logic [PWM_CHANNELS-1:0] pad_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Released pads float up to the pull-up, never to the last level
   assign pad_o = (pwm_pin_o & ~pwm_pin_oe_n_o) | pwm_pin_oe_n_o;

   // Quiet lines at start
   initial begin
      event_o = 1'b0;
      cap_o = '0;
   end

   // Four cycles high and five low so the two-stage sync cannot miss an edge
   task automatic send_events(input int n);
      repeat (n) begin
         @(posedge clk_i);
         event_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         event_o <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask

   // One capture line level change, then settle time for sync and detect
   task automatic set_cap(input int ch, input logic lvl);
      @(posedge clk_i);
      cap_o[ch] <= lvl;
      repeat (8) @(posedge clk_i);
   endtask
endmodule // pins_model

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the PWM auto-reload timer
`default_nettype none

module tb
   import pwm_art_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Signals and bookkeeping
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b1;
   logic [7:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] be = '0;
   logic halt = 1'b0;
   logic [31:0] rdata;
   logic waitreq, ovf_irq, ev;
   logic [1:0] cap_irq, cap;
   logic [3:0] pwm, oe_n, pad;
   logic [7:0] got;
   logic [5:0] rw_idx[6] = '{IDX_DUTY0, IDX_DUTY1, IDX_DUTY2, IDX_DUTY3, IDX_PWM_CTRL,
      IDX_RELOAD};
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int acc_cyc = 0;

   pwm_autoreload_timer i_dut (.clk_i, .reset_n_i, .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .halt_i(halt),
      .external_event_clock_i(ev), .capture_input_pin_i(cap), .pwm_pin_o(pwm),
      .pwm_pin_oe_n_o(oe_n), .overflow_irq_o(ovf_irq), .capture_irq_o(cap_irq));
   pins_model i_pins (.clk_i, .pwm_pin_o(pwm), .pwm_pin_oe_n_o(oe_n), .event_o(ev),
      .cap_o(cap), .pad_o(pad));

   // 100 MHz clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // Cycle count doubles as the hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Tasks and expectation functions
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Held until waitrequest is seen low; data and accept time taken there
   task automatic access(input logic w, input logic [5:0] idx, input logic [7:0] d,
         input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk_i);
      addr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      be <= b;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) fails++;
      got = rdata[7:0];
      acc_cyc = cyc;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d);
      access(1'b1, idx, d, 4'h1);
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
      access(1'b0, idx, 8'h00, 4'h1);
      chk(got, exp);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // High cycles over eight periods with reload f8
   function automatic int high_cnt(input logic [7:0] d, input logic pol);
      int h;
      h = 8 * (int'(d) - 247);
      return pol ? 64 - h : h;
   endfunction

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int t0;
      int h[4];
      logic [7:0] v, r;
      logic [7:0] d[4];
      logic [3:0] pol, oe;
      // Falling edge at time zero puts every flop in reset at once
      reset_n_i <= 1'b0;
      void'($urandom(32'h5bf7));
      cycles(16);
      reset_n_i <= 1'b1;
      // Reset values, and an unmapped write that must vanish
      for (int i = 20; i <= 30; i++) rd_chk(6'(i), 8'h00);
      wr_reg(6'h3f, 8'h5a);
      rd_chk(6'h3f, 8'h00);
      $display("test reset_values done");
      // Random read/write; a write with its byte lane off is dropped
      foreach (rw_idx[j]) begin
         v = 8'($urandom);
         wr_reg(rw_idx[j], v);
         access(1'b1, rw_idx[j], ~v, 4'h0);
         rd_chk(rw_idx[j], v);
      end
      v = 8'($urandom);
      wr_reg(IDX_TIMER_CSR, v & 8'hf7);
      rd_chk(IDX_TIMER_CSR, v & 8'hf2);
      wr_reg(IDX_COUNTER, v);
      rd_chk(IDX_COUNTER, v);
      wr_reg(IDX_PWM_CTRL, 8'h00);
      $display("test registers done");
      // Every divider tap; the counter write also clears the prescaler
      for (int n = 0; n < 8; n++) begin
         wr_reg(IDX_COUNTER, 8'h00);
         wr_reg(IDX_TIMER_CSR, {1'b0, 3'(n), 4'h8});
         t0 = acc_cyc;
         cycles(20 + $urandom_range(170));
         wr_reg(IDX_TIMER_CSR, 8'h00);
         v = 8'((acc_cyc - t0) >> n);
         rd_chk(IDX_COUNTER, v);
         cycles(5);
         rd_chk(IDX_COUNTER, v);
      end
      $display("test prescaler done");
      // Overflow reload, sticky flag, clear on read
      r = 8'hf0 + 8'($urandom_range(14));
      wr_reg(IDX_RELOAD, r);
      wr_reg(IDX_TIMER_CSR, 8'h0e);
      t0 = acc_cyc;
      cycles(40);
      wr_reg(IDX_TIMER_CSR, 8'h02);
      rd_chk(IDX_COUNTER, 8'(int'(r) + (acc_cyc - t0) % (256 - int'(r))));
      chk(ovf_irq, 1'b1);
      rd_chk(IDX_TIMER_CSR, 8'h03);
      cycles(1);
      chk(ovf_irq, 1'b0);
      rd_chk(IDX_TIMER_CSR, 8'h02);
      $display("test overflow done");
      // PWM duty, polarity and pin release; duty kept above reload
      wr_reg(IDX_RELOAD, 8'hf8);
      for (int k = 0; k < 3; k++) begin
         pol = 4'($urandom);
         oe = 4'($urandom);
         foreach (d[c]) d[c] = 8'hf9 + 8'($urandom_range(6));
         foreach (d[c]) wr_reg(rw_idx[c], d[c]);
         wr_reg(IDX_PWM_CTRL, {oe, pol});
         wr_reg(IDX_TIMER_CSR, 8'h0c);
         cycles(20);
         h = '{0, 0, 0, 0};
         repeat (64) begin
            @(negedge clk_i);
            foreach (h[c]) h[c] += int'(pwm[c]);
         end
         foreach (h[c]) chk(h[c], high_cnt(d[c], pol[c]));
         chk(oe_n, 4'(~oe));
      end
      // Halt freezes waveform and control writes
      @(posedge clk_i) halt <= 1'b1;
      wr_reg(IDX_PWM_CTRL, 8'h00);
      cycles(30);
      rd_chk(IDX_PWM_CTRL, {oe, pol});
      @(posedge clk_i) halt <= 1'b0;
      wr_reg(IDX_TIMER_CSR, 8'h00);
      wr_reg(IDX_PWM_CTRL, 8'h00);
      $display("test pwm done");
      // External events: three to overflow, the last one in halt
      wr_reg(IDX_RELOAD, 8'hfd);
      wr_reg(IDX_TIMER_CSR, 8'h8e);
      access(1'b0, IDX_TIMER_CSR, 8'h00, 4'h1);
      i_pins.send_events(2);
      cycles(6);
      rd_chk(IDX_COUNTER, 8'hff);
      chk(ovf_irq, 1'b0);
      @(posedge clk_i) halt <= 1'b1;
      i_pins.send_events(1);
      cycles(6);
      chk(ovf_irq, 1'b1);
      @(posedge clk_i) halt <= 1'b0;
      rd_chk(IDX_TIMER_CSR, 8'h8b);
      rd_chk(IDX_COUNTER, 8'hfd);
      wr_reg(IDX_TIMER_CSR, 8'h00);
      $display("test events done");
      // Capture: edge select, blocking while flagged, halt keeps wake-up only
      wr_reg(IDX_COUNTER, 8'h3c);
      wr_reg(IDX_CAPTURE_CSR, 8'h1c);
      i_pins.set_cap(0, 1'b1);
      chk(cap_irq, 2'b01);
      rd_chk(IDX_CAPTURE1, 8'h3c);
      wr_reg(IDX_COUNTER, 8'h77);
      i_pins.set_cap(0, 1'b0);
      i_pins.set_cap(0, 1'b1);
      rd_chk(IDX_CAPTURE1, 8'h3c);
      i_pins.set_cap(1, 1'b1);
      chk(cap_irq, 2'b01);
      i_pins.set_cap(1, 1'b0);
      chk(cap_irq, 2'b11);
      rd_chk(IDX_CAPTURE2, 8'h77);
      rd_chk(IDX_CAPTURE_CSR, 8'h1f);
      cycles(1);
      chk(cap_irq, 2'b00);
      wr_reg(IDX_COUNTER, 8'h99);
      @(posedge clk_i) halt <= 1'b1;
      i_pins.set_cap(1, 1'b1);
      i_pins.set_cap(1, 1'b0);
      chk(cap_irq, 2'b10);
      @(posedge clk_i) halt <= 1'b0;
      rd_chk(IDX_CAPTURE2, 8'h77);
      i_pins.set_cap(0, 1'b0);
      $display("test capture done");
      // Reset in mid-run
      wr_reg(IDX_RELOAD, 8'h42);
      @(posedge clk_i) reset_n_i <= 1'b0;
      cycles(3);
      @(posedge clk_i) reset_n_i <= 1'b1;
      rd_chk(IDX_RELOAD, 8'h00);
      rd_chk(IDX_COUNTER, 8'h00);
      $display("test second_reset done");
      end_sim();
   end
endmodule // tb

`default_nettype wire
